//--- rtl/vplrs_top.sv
// video loop lock sequencer: lock state of one video synthesis loop,
// reached over apb, with sticky events and one interrupt output.
// assumes reference_clock edges arrive as a one-cycle pulse ref_tick in clk_sys.
//
// Contract
// - writing trigger bit 0 starts lock attempt
// - success shows lock bit1 and init-done bit0
// - first attempt may fail during initialisation
// - a later retrigger locks without other recovery
`timescale 1ns/1ps
module vplrs_top #(
   parameter int unsigned LOCK_REF = vplrs_pkg::LOCK_REF_CYCLES, // ref edges to lock
   parameter int unsigned INIT_CNT = vplrs_pkg::INIT_CYCLES, // init-done delay
   parameter int unsigned LOSS_CNT = vplrs_pkg::REF_LOSS_CYCLES // missing-ref gap
)(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_tick,
   input wire logic jitter_alarm,
   input wire logic fail_first_attempt,
   output logic loop_locked,
   output logic irq
);

   // ==========================================================
   // helpers
   // ==========================================================
   // saturating count, shared by the init, gap and reference counters;
   // saturation keeps a stalled counter from wrapping back to zero
   function automatic logic [31:0] sat_inc(input logic [31:0] value);
      if (value == 32'hffff_ffff)
         return value;
      return value + 32'h0000_0001;
   endfunction

   // byte-lane merge of an apb write into a stored word
   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0] strobe
   );
      logic [31:0] merged; // word being built lane by lane
      merged = old_word;
      for (int lane = 0; lane < 4; lane++)
      begin
         if (strobe[lane])
            merged[lane*8 +: 8] = new_word[lane*8 +: 8];
      end
      return merged;
   endfunction

   // ==========================================================
   // apb decode
   // ==========================================================
   wire logic setup_phase; // psel high, penable low
   wire logic access_phase; // psel and penable high
   wire logic wr_access; // write takes effect at this edge
   wire logic sel_trigger; // lock_trigger_control addressed
   wire logic sel_flags; // loop_state_flags addressed
   wire logic sel_cfg; // loop configuration addressed
   wire logic sel_irq_status; // sticky events addressed
   wire logic sel_irq_mask; // event enables addressed
   wire logic addr_ok; // a mapped register is addressed

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign wr_access = access_phase & pwrite;
   assign sel_trigger = (paddr == vplrs_pkg::OFS_LOCK_TRIGGER_CONTROL);
   assign sel_flags = (paddr == vplrs_pkg::OFS_LOOP_STATE_FLAGS);
   assign sel_cfg = (paddr == vplrs_pkg::OFS_LOOP_CONFIG);
   assign sel_irq_status = (paddr == vplrs_pkg::OFS_IRQ_STATUS);
   assign sel_irq_mask = (paddr == vplrs_pkg::OFS_IRQ_MASK);
   assign addr_ok = sel_trigger | sel_flags | sel_cfg | sel_irq_status | sel_irq_mask;

   // ==========================================================
   // state
   // ==========================================================
   vplrs_pkg::vplrs_state_type state_reg; // sequencer state
   vplrs_pkg::vplrs_state_type state_next;
   logic [31:0] init_cnt_reg; // cycles since reset, held once it reaches INIT_CNT
   logic [31:0] init_cnt_next;
   logic [31:0] gap_reg; // clk_sys cycles since the last ref_tick
   logic [31:0] gap_next;
   logic [31:0] ref_cnt_reg; // reference edges seen in this attempt
   logic [31:0] ref_cnt_next;
   logic tried_reg; // an attempt was started since reset
   logic tried_next;
   logic doomed_reg; // this attempt is the first one and is told to fail
   logic doomed_next;
   logic jitter_reg; // excess_jitter_flag, registered alarm
   logic [31:0] cfg_reg; // loop configuration
   logic [31:0] cfg_next;
   logic [vplrs_pkg::IRQ_W-1:0] irq_status_reg; // sticky events
   logic [vplrs_pkg::IRQ_W-1:0] irq_status_next;
   logic [vplrs_pkg::IRQ_W-1:0] irq_mask_reg; // event enables
   logic [vplrs_pkg::IRQ_W-1:0] irq_mask_next;
   logic [31:0] prdata_reg; // read data, captured in the setup phase
   logic [31:0] prdata_next;
   logic loop_locked_reg; // registered lock indication

   // ==========================================================
   // loop conditions
   // ==========================================================
   wire logic init_done; // ctrl_init_done_flag
   wire logic ref_missing; // ref_missing_flag
   wire logic loop_error; // any error flag that spoils a lock
   wire logic busy; // an attempt is in progress
   wire logic locked_now; // loop holds a good lock
   wire logic failed_now; // last attempt failed or a held lock was lost, calibration_redo_flag
   wire logic count_done; // enough reference edges to settle
   wire logic trig_write; // software wrote the go bit
   wire logic trig_accept; // go bit honoured
   wire logic lock_evt; // attempt ends locked
   wire logic fail_evt; // attempt ends failed
   wire logic lost_evt; // a held lock is spoiled by an error
   wire logic [vplrs_pkg::IRQ_W-1:0] irq_clear; // write-one-to-clear mask
   logic [vplrs_pkg::IRQ_W-1:0] irq_set; // events of this cycle

   assign init_done = (init_cnt_reg >= INIT_CNT);
   assign ref_missing = (gap_reg >= LOSS_CNT);
   assign loop_error = jitter_reg | ref_missing;
   assign busy = (state_reg == vplrs_pkg::VPLRS_LOCKING);
   assign locked_now = (state_reg == vplrs_pkg::VPLRS_LOCKED);
   assign failed_now = (state_reg == vplrs_pkg::VPLRS_FAILED);
   assign count_done = (ref_cnt_reg >= LOCK_REF);
   // a go bit written before init completes is dropped; software then
   // sees no progress, times out and writes it again
   assign trig_write = wr_access & sel_trigger & pstrb[0]
      & pwdata[vplrs_pkg::TRIG_GO_BIT];
   assign trig_accept = trig_write & init_done;
   assign lock_evt = busy & (state_next == vplrs_pkg::VPLRS_LOCKED);
   assign fail_evt = busy & (state_next == vplrs_pkg::VPLRS_FAILED);
   assign lost_evt = locked_now & (state_next == vplrs_pkg::VPLRS_FAILED);
   assign irq_clear = (wr_access & sel_irq_status & pstrb[0])
      ? pwdata[vplrs_pkg::IRQ_W-1:0] : '0;

   // ==========================================================
   // status word and read mux
   // ==========================================================
   logic [31:0] status_word; // loop_state_flags as software sees it
   logic [31:0] read_word; // word selected by paddr

   // flags are live: a lock is good only while every error bit reads zero
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[vplrs_pkg::ST_INIT_DONE_BIT] = init_done;
      status_word[vplrs_pkg::ST_LOCK_BIT] = locked_now;
      status_word[vplrs_pkg::ST_RECAL_BIT] = failed_now;
      status_word[vplrs_pkg::ST_REFMISS_BIT] = ref_missing;
      status_word[vplrs_pkg::ST_JITTER_BIT] = jitter_reg;
      status_word[vplrs_pkg::ST_BYPASS_BIT] = cfg_reg[vplrs_pkg::CFG_BYPASS_BIT];
   end

   // read decode; unmapped offsets read zero and raise pslverr
   always_comb
   begin
      read_word = 32'h0000_0000;
      if (sel_trigger)
         read_word[vplrs_pkg::TRIG_GO_BIT] = busy; // go bit reads as busy
      else if (sel_flags)
         read_word = status_word;
      else if (sel_cfg)
         read_word = cfg_reg;
      else if (sel_irq_status)
         read_word[vplrs_pkg::IRQ_W-1:0] = irq_status_reg;
      else if (sel_irq_mask)
         read_word[vplrs_pkg::IRQ_W-1:0] = irq_mask_reg;
   end

   // ==========================================================
   // sequencer
   // ==========================================================
   // a go bit in any settled state starts a fresh attempt; the first
   // attempt after reset may be told to fail, and a retrigger then locks
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         vplrs_pkg::VPLRS_INIT:
         begin
            if (init_done)
               state_next = vplrs_pkg::VPLRS_IDLE;
         end
         vplrs_pkg::VPLRS_IDLE, vplrs_pkg::VPLRS_FAILED:
         begin
            if (trig_accept)
               state_next = vplrs_pkg::VPLRS_LOCKING;
         end
         vplrs_pkg::VPLRS_LOCKING:
         begin
            if (trig_accept)
               state_next = vplrs_pkg::VPLRS_LOCKING; // restart the count
            else if (count_done && (doomed_reg || loop_error))
               state_next = vplrs_pkg::VPLRS_FAILED;
            else if (count_done)
               state_next = vplrs_pkg::VPLRS_LOCKED;
         end
         vplrs_pkg::VPLRS_LOCKED:
         begin
            if (trig_accept)
               state_next = vplrs_pkg::VPLRS_LOCKING;
            else if (loop_error)
               state_next = vplrs_pkg::VPLRS_FAILED; // error spoils the lock
         end
         default:
         begin
            state_next = vplrs_pkg::VPLRS_INIT;
         end
      endcase
   end

   // ==========================================================
   // counters and attempt bookkeeping
   // ==========================================================
   // init counter stops once done; the gap counter restarts on every
   // reference edge, so a stopped reference shows as ref_missing_flag
   always_comb
   begin
      init_cnt_next = init_cnt_reg;
      if (!init_done)
         init_cnt_next = sat_inc(init_cnt_reg);
      gap_next = ref_tick ? 32'h0000_0000 : sat_inc(gap_reg);
      ref_cnt_next = ref_cnt_reg;
      if (trig_accept)
         ref_cnt_next = 32'h0000_0000;
      else if (busy && ref_tick)
         ref_cnt_next = sat_inc(ref_cnt_reg);
      tried_next = tried_reg | trig_accept;
      doomed_next = doomed_reg;
      if (trig_accept)
         doomed_next = fail_first_attempt & ~tried_reg;
   end

   // ==========================================================
   // software registers
   // ==========================================================
   // configuration is frozen while an attempt runs, so a late write
   // cannot move the loop under a lock in progress
   always_comb
   begin
      cfg_next = cfg_reg;
      if (wr_access && sel_cfg && !busy)
         cfg_next = merge_bytes(cfg_reg, pwdata, pstrb);
      irq_mask_next = irq_mask_reg;
      if (wr_access && sel_irq_mask && pstrb[0])
         irq_mask_next = pwdata[vplrs_pkg::IRQ_W-1:0];
      // read data is one cycle old by the access phase; a limitation
      // traded for a registered prdata with no wait states
      prdata_next = prdata_reg;
      if (setup_phase && !pwrite)
         prdata_next = read_word;
   end

   // an event sets its bit even when software clears it in the same cycle
   always_comb
   begin
      irq_set = '0;
      irq_set[vplrs_pkg::IRQ_LOCKED_BIT] = lock_evt;
      irq_set[vplrs_pkg::IRQ_FAILED_BIT] = fail_evt;
      irq_set[vplrs_pkg::IRQ_LOST_BIT] = lost_evt;
      irq_status_next = (irq_status_reg & ~irq_clear) | irq_set;
   end

   // ==========================================================
   // flip-flops
   // ==========================================================
   // sequencer and counters
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= vplrs_pkg::VPLRS_INIT;
         init_cnt_reg <= 32'h0000_0000;
         gap_reg <= 32'h0000_0000;
         ref_cnt_reg <= 32'h0000_0000;
         tried_reg <= 1'b0;
         doomed_reg <= 1'b0;
         jitter_reg <= 1'b0;
         loop_locked_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         init_cnt_reg <= init_cnt_next;
         gap_reg <= gap_next;
         ref_cnt_reg <= ref_cnt_next;
         tried_reg <= tried_next;
         doomed_reg <= doomed_next;
         jitter_reg <= jitter_alarm;
         loop_locked_reg <= (state_next == vplrs_pkg::VPLRS_LOCKED);
      end
   end

   // software-visible registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_reg <= vplrs_pkg::CFG_RESET;
         irq_status_reg <= '0;
         irq_mask_reg <= vplrs_pkg::IRQ_MASK_RESET;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         cfg_reg <= cfg_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         prdata_reg <= prdata_next;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   // zero wait states: every access phase is answered at once
   assign pready = access_phase;
   // writes to the read-only flags are refused as well as unmapped offsets
   assign pslverr = access_phase & (~addr_ok | (pwrite & sel_flags));
   assign prdata = prdata_reg;
   assign loop_locked = loop_locked_reg;
   assign irq = |(irq_status_reg & irq_mask_reg);

endmodule // vplrs_top

//--- rtl/vplrs_pkg.sv
// register map, status field layout, reset values and timing counts
// for the video loop lock sequencer.
// assumes a 32-bit apb slave clocked by clk_sys at 10 mhz.
package vplrs_pkg;

   // ==========================================================
   // clock
   // ==========================================================
   localparam int unsigned CLK_PERIOD_NS = 100; // clk_sys period

   // ==========================================================
   // register byte offsets
   // ==========================================================
   localparam logic [7:0] OFS_LOCK_TRIGGER_CONTROL = 8'h00; // trigger, reads busy
   localparam logic [7:0] OFS_LOOP_STATE_FLAGS = 8'h04; // loop status, read only
   localparam logic [7:0] OFS_LOOP_CONFIG = 8'h08; // loop configuration
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c; // sticky events, write one to clear
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10; // event enables

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int unsigned TRIG_GO_BIT = 0; // start a lock attempt
   localparam int unsigned ST_INIT_DONE_BIT = 0; // ctrl_init_done_flag
   localparam int unsigned ST_LOCK_BIT = 1; // loop locked
   localparam int unsigned ST_RECAL_BIT = 2; // calibration_redo_flag
   localparam int unsigned ST_REFMISS_BIT = 3; // ref_missing_flag
   localparam int unsigned ST_JITTER_BIT = 5; // excess_jitter_flag
   localparam int unsigned ST_BYPASS_BIT = 6; // passthrough flag
   localparam int unsigned CFG_BYPASS_BIT = 0; // force passthrough
   localparam int unsigned CFG_MULT_LSB = 8; // multiplier field
   localparam int unsigned CFG_MULT_W = 12;
   localparam int unsigned IRQ_LOCKED_BIT = 0; // attempt ended locked
   localparam int unsigned IRQ_FAILED_BIT = 1; // attempt ended failed
   localparam int unsigned IRQ_LOST_BIT = 2; // error flag rose while locked
   localparam int unsigned IRQ_W = 3;

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [31:0] CFG_RESET = 32'h0000_0100; // multiplier 1, no bypass
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int unsigned INIT_TIME_NS = 2000; // controller init, least time
   localparam int unsigned INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REF_LOSS_TIME_NS = 10000; // gap that counts as missing
   localparam int unsigned REF_LOSS_CYCLES = REF_LOSS_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned LOCK_REF_CYCLES = 100; // reference edges to settle

   // ==========================================================
   // loop states
   // ==========================================================
   typedef enum logic [2:0]
   {
      VPLRS_INIT = 3'b000,
      VPLRS_IDLE = 3'b001,
      VPLRS_LOCKING = 3'b010,
      VPLRS_LOCKED = 3'b011,
      VPLRS_FAILED = 3'b100
   } vplrs_state_type;

endpackage

//--- verif/vplrs_assertions.sv
// checker on the sequencer ports, bound to every vplrs_top
// assumes one clock domain with an active-low reset
`timescale 1ns/1ps
module vplrs_assertions (input wire logic clk_sys, rst_n, psel, penable,
   pready, pslverr, loop_locked, irq);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // a stuck slave would hang software, so the wait is bounded
   a_ready_bounded: assert property (psel && penable |-> ##[0:8] pready)
      else $error("access phase left unanswered");
   a_unlocked_after_reset: assert property ($rose(rst_n) |-> !loop_locked)
      else $error("loop locked without a trigger");
   a_quiet_irq_reset: assert property ($rose(rst_n) |-> !irq)
      else $error("interrupt raised with all events masked");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error response without ready");
endmodule // vplrs_assertions
bind vplrs_top vplrs_assertions chk (.clk_sys, .rst_n, .psel, .penable, .pready, .pslverr,
   .loop_locked, .irq);

//--- verif/vplrs_ref_source.sv
// reference edge source: one clk_sys-wide pulse every PERIOD cycles
// it runs free, as a crystal would
`timescale 1ns/1ps
module vplrs_ref_source #(parameter int PERIOD = 4) (input wire logic clk_sys,
   output logic ref_tick);
   int cnt = 0;
   always @(posedge clk_sys) cnt <= (cnt + 1) % PERIOD;
   assign ref_tick = (cnt == 0);
endmodule // vplrs_ref_source

//--- verif/vplrs_top_tb.sv
// bench: lock sequence with retries, then the lock interrupt
// assumes the ref source model and the design package
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
   $display("unexpected %0t value mismatch", $time); end end
module vplrs_top_tb;
   logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, ref_tick, locked, irq;
   logic jitter_alarm = 0, fail_first = 1, err;
   int fail_count = 0, tests_run = 0, cyc = 0, refs = 0, tries, t0;
   vplrs_top #(.LOCK_REF(8), .INIT_CNT(4), .LOSS_CNT(40)) dut (.clk_sys, .rst_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
      .ref_tick, .jitter_alarm, .fail_first_attempt(fail_first), .loop_locked(locked), .irq);
   vplrs_ref_source #(.PERIOD(4)) src (.clk_sys, .ref_tick);
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin cyc++; refs += ref_tick; if (cyc == 95000) begin
      fail_count++; conclude(); end end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys) penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata; err = pslverr; psel <= 0; penable <= 0;
      @(posedge clk_sys);
   endtask
   task automatic conclude();
      if (fail_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1;
      apb(1, vplrs_pkg::OFS_IRQ_MASK, 32'h1);
      apb(1, vplrs_pkg::OFS_LOOP_CONFIG, vplrs_pkg::CFG_RESET);
      tries = 0; rd = 0;
      while (tries < 20 && (rd & 32'h6f) !== 32'h3) begin
         tries++; apb(1, vplrs_pkg::OFS_LOCK_TRIGGER_CONTROL, 32'h1);
         t0 = refs;
         do apb(0, vplrs_pkg::OFS_LOOP_STATE_FLAGS, 32'h0);
         while ((rd & 32'h6f) !== 32'h3 && (rd & 32'h6c) == 32'h0
            && refs - t0 < 1000);
      end
      `CHK(rd & 32'h6f, 32'h3)
      `CHK(tries > 1, 1'b1)
      `CHK(locked, 1'b1)
      `CHK(irq, 1'b1)
      apb(1, vplrs_pkg::OFS_IRQ_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      apb(0, vplrs_pkg::OFS_LOOP_CONFIG, 32'h0);
      `CHK(rd, vplrs_pkg::CFG_RESET)
      `CHK(err, 1'b0)
      apb(0, 8'h20, 32'h0);
      `CHK(err, 1'b1)
      jitter_alarm <= 1;
      repeat (3) @(posedge clk_sys);
      apb(0, vplrs_pkg::OFS_LOOP_STATE_FLAGS, 32'h0);
      `CHK(rd & 32'h6f, 32'h25)
      `CHK(locked, 1'b0)
      apb(0, vplrs_pkg::OFS_IRQ_STATUS, 32'h0);
      `CHK(rd & 32'h6, 32'h6)
      conclude();
   end
endmodule // vplrs_top_tb
